// ---- core/seek_pkg.sv ----
// Purpose: shared constants and types of the seek and spare manager
// Assumes: core clock of 200 MHz
// Notes: physical address is {head[1:0], track[7:0], sector[3:0]}
package seek_pkg;

	// ----------------------------------------
	// Clock and times
	// ----------------------------------------
	localparam real CLK_HZ = 200.0e6;
	localparam real LAMP_MIN_S = 0.5;
	localparam real LAMP_MAX_S = 3.0;
	localparam real SPIN_S = 20.0;
	localparam real STEP_S = 0.003;
	// Least times round up to whole cycles
	localparam logic [31:0] LAMP_CYC = 32'($ceil(LAMP_MIN_S * CLK_HZ));
	localparam logic [31:0] SPIN_CYC = 32'($ceil(SPIN_S * CLK_HZ));
	localparam logic [31:0] STEP_CYC = 32'($ceil(STEP_S * CLK_HZ));

	// ----------------------------------------
	// Geometry
	// ----------------------------------------
	localparam logic [7:0] TRK_RSV = 8'h4d;
	localparam logic [7:0] TRK_OUTER = 8'h00;
	localparam logic [7:0] TRK_INNER = 8'h9b;
	localparam logic [7:0] TRK_PARK = 8'h00;
	localparam logic [1:0] HEAD_SPARE = 2'h0;
	localparam logic [1:0] HEAD_TABLE = 2'h2;
	localparam logic [3:0] IL_FIRST = 4'h5;
	localparam logic [3:0] IL_SECOND = 4'h7;
	localparam int LBA_TRK_LSB = 6;

	// ----------------------------------------
	// Limits
	// ----------------------------------------
	localparam logic [6:0] ERR_LIMIT = 7'h40;
	localparam logic [1:0] VER_LAST = 2'h2;
	localparam logic [2:0] RECAL_STEPS = 3'h4;
	localparam logic [5:0] SPARE_MAX = 6'h20;
	localparam logic [5:0] TBL_LAST = 6'h1f;

	typedef logic [13:0] paddr_t;

	typedef enum logic [3:0] {
		S_LAMP = 4'b0000,
		S_SPIN = 4'b0001,
		S_IDLE = 4'b0010,
		S_LOOK = 4'b0011,
		S_LCMP = 4'b0100,
		S_STEP = 4'b0101,
		S_SWAIT = 4'b0110,
		S_VER = 4'b0111,
		S_LOAD = 4'b1000,
		S_XFER = 4'b1001,
		S_SCOPY = 4'b1010,
		S_TBLW = 4'b1011,
		S_DEAD = 4'b1100
	} st_t;

endpackage

// ---- core/reloc_if.sv ----
// Purpose: port of the relocation table memory
// Assumes: one write port, one registered read port
// Notes: owner drives address and write, store answers
`timescale 1ns/1ps
interface reloc_if;
	import seek_pkg::*;
	logic we;
	logic [4:0] waddr;
	paddr_t wdata;
	logic [4:0] raddr;
	paddr_t rdata;
	modport owner (output we, output waddr, output wdata, output raddr, input rdata);
	modport store (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

// ---- core/reloc_ram.sv ----
// Purpose: RAM copy of the relocation table, 32 original addresses
// Assumes: read data one cycle after the address
// Notes: entry index is the spare slot index
`timescale 1ns/1ps
module reloc_ram
	import seek_pkg::*;
(
	input wire logic core_clk,
	reloc_if.store bus
);
	typedef struct packed {
		logic [31:0][13:0] mem;
		paddr_t rd;
	} ram_t;

	ram_t s_r;
	ram_t s_nxt;

	// Write and registered read; no reset, contents reload at power-up
	always_comb begin
		s_nxt = s_r;
		s_nxt.rd = s_r.mem[bus.raddr];
		if (bus.we) begin
			s_nxt.mem[bus.waddr] = bus.wdata;
		end
	end

	always_ff @(posedge core_clk) begin
		s_r <= s_nxt;
	end

	assign bus.rdata = s_r.rd;
endmodule // reloc_ram

// ---- core/seek_spare_mgr.sv ----
// Purpose: power-up, seek verify, block mapping and sector sparing
// Assumes: media side decodes headers and returns CRC status
// Notes: one media operation at a time, med_done ends it
//
// Operation
// - First host format: interleave five positions
// - Second host format: interleave seven positions
// - Track 77 never mapped to host blocks
// - Refuse reserved-track writes unless formatting
// - At most 32 relocated sectors
// - Copy salvaged data to spare track
// - Record original and spare location pair
// - Rewrite all 32 table sectors per relocation
// - Reads search RAM table, follow relocation
// - Translate logical block to physical address
// - No host traffic before power-up completes
// - Ready lamp lit 0.5 to 3 seconds
// - Wait 20 seconds, lamp off, spin-up
// - Seek table track, load relocation table
// - Seek steps to target, then verifies
// - Verify reads three alternate sector headers
// - Three good sectors end the seek
// - Table load takes first good-CRC sector
// - Reread alternates until 64 errors
// - Beyond 64: recalibrate outer, then inner
// - Recalibration cycle done twice
// - Still unconfirmed: park heads during power-up, otherwise abandon, with an error response for host transfers only (none for sparing seeks)
// - No transfer while heads are stepping
// - Header complements checked during verify
`timescale 1ns/1ps
module seek_spare_mgr
	import seek_pkg::*;
#(
	parameter logic [31:0] LAMP_CYCLES = LAMP_CYC,
	parameter logic [31:0] SPIN_CYCLES = SPIN_CYC,
	parameter logic [31:0] STEP_CYCLES = STEP_CYC
) (
	input wire logic core_clk,
	input wire logic reset,
	// Host side
	input wire logic req_valid,
	output logic req_ready,
	input wire logic req_write,
	input wire logic req_raw,
	input wire logic [13:0] req_lba,
	input wire logic [7:0] req_track,
	input wire logic format_mode,
	input wire logic host_type,
	output logic resp_valid,
	output logic resp_error,
	output paddr_t resp_addr,
	// Sparing request from the retry logic
	input wire logic spare_req,
	input wire paddr_t spare_addr,
	output logic spare_done,
	output logic spare_full,
	// Stepper and status
	output logic step_pulse,
	output logic step_dir,
	output logic ready_lamp,
	output logic parked_fail,
	// Media operations
	output logic med_go,
	output logic med_write,
	output logic [1:0] med_head,
	output logic [7:0] med_track,
	output logic [3:0] med_sector,
	input wire logic med_done,
	input wire logic med_hdr_ok,
	input wire logic [1:0] med_hdr_head,
	input wire logic [1:0] med_hdr_head_n,
	input wire logic [7:0] med_hdr_track,
	input wire logic [7:0] med_hdr_track_n,
	input wire logic med_crc_ok,
	input wire logic med_ent_valid,
	input wire paddr_t med_ent
);
	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		st_t st;
		st_t ret;
		logic [31:0] tmr;
		logic [7:0] cur;
		logic [7:0] dst;
		logic [7:0] tgt;
		logic [1:0] hd;
		logic [3:0] sec;
		logic ext;
		logic [6:0] errs;
		logic [2:0] rph;
		logic [1:0] vi;
		logic wt;
		logic go;
		logic wr;
		logic stp;
		logic dir;
		logic up;
		logic fail;
		logic [5:0] tcnt;
		logic [5:0] si;
		paddr_t orig;
		logic rv;
		logic rerr;
		logic sdone;
	} mgr_t;

	mgr_t s_r;
	mgr_t s_nxt;

	reloc_if rt ();

	reloc_ram u_ram (
		.core_clk(core_clk),
		.bus(rt.store)
	);

	// Start a verified seek to tgt, returning to r afterwards
	function automatic mgr_t start_seek(input mgr_t a, input st_t r);
		mgr_t b;
		b = a;
		b.dst = a.tgt;
		b.ext = 1'b0;
		b.errs = '0;
		b.rph = '0;
		b.vi = '0;
		b.wt = 1'b0;
		b.ret = r;
		b.st = S_STEP;
		return b;
	endfunction

	// ----------------------------------------
	// Host address translation
	// ----------------------------------------
	logic [7:0] lba_trk;
	logic [7:0] host_trk;
	logic [3:0] il_step;
	logic [3:0] host_pos;
	logic hdr_good;

	// Skip the reserved track so no block lands on it
	assign lba_trk = 8'(req_lba[13:LBA_TRK_LSB]);
	assign host_trk = req_raw ? req_track : ((lba_trk >= TRK_RSV) ? lba_trk + 8'h01 : lba_trk);
	assign il_step = host_type ? IL_SECOND : IL_FIRST;
	assign host_pos = 4'(req_lba[3:0] * il_step);

	// Header fields must match the target and their complements
	assign hdr_good = med_hdr_ok && (med_hdr_head == s_r.hd) && (med_hdr_track == s_r.tgt) &&
		(med_hdr_head_n == ~med_hdr_head) && (med_hdr_track_n == ~med_hdr_track) && med_crc_ok;

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		s_nxt = s_r;
		s_nxt.go = 1'b0;
		s_nxt.stp = 1'b0;
		s_nxt.rv = 1'b0;
		s_nxt.sdone = 1'b0;
		rt.we = 1'b0;
		rt.waddr = s_r.tcnt[4:0];
		rt.wdata = med_ent;
		rt.raddr = s_r.si[4:0];
		unique case (s_r.st)
			// Lamp on while supplies settle
			S_LAMP: begin
				s_nxt.tmr = s_r.tmr + 32'h0000_0001;
				if (s_r.tmr == LAMP_CYCLES - 32'h0000_0001) begin
					s_nxt.tmr = '0;
					s_nxt.st = S_SPIN;
				end
			end
			// Lamp off during spindle spin-up
			S_SPIN: begin
				s_nxt.tmr = s_r.tmr + 32'h0000_0001;
				if (s_r.tmr == SPIN_CYCLES - 32'h0000_0001) begin
					s_nxt.tmr = '0;
					s_nxt.tgt = TRK_RSV;
					s_nxt.hd = HEAD_TABLE;
					s_nxt.si = '0;
					s_nxt.tcnt = '0;
					s_nxt = start_seek(s_nxt, S_LOAD);
				end
			end
			// Sparing first, then host requests
			S_IDLE: begin
				if (spare_req && (s_r.tcnt < SPARE_MAX)) begin
					s_nxt.orig = spare_addr;
					s_nxt.si = s_r.tcnt;
					s_nxt.tgt = TRK_RSV;
					s_nxt.hd = {1'b0, s_r.tcnt[4]} | HEAD_SPARE;
					s_nxt.sec = s_r.tcnt[3:0];
					s_nxt.wr = 1'b1;
					s_nxt = start_seek(s_nxt, S_SCOPY);
				end else if (req_valid) begin
					s_nxt.tgt = host_trk;
					s_nxt.hd = req_lba[5:4];
					s_nxt.sec = host_pos;
					s_nxt.wr = req_write;
					s_nxt.orig = {req_lba[5:4], host_trk, host_pos};
					s_nxt.si = '0;
					if (req_write && (host_trk == TRK_RSV) && !format_mode) begin
						s_nxt.rv = 1'b1;
						s_nxt.rerr = 1'b1;
					end else begin
						s_nxt.st = S_LOOK;
					end
				end
			end
			// Walk the RAM table, two cycles an entry
			S_LOOK: begin
				if (s_r.si == s_r.tcnt) begin
					s_nxt = start_seek(s_nxt, S_XFER);
				end else begin
					s_nxt.st = S_LCMP;
				end
			end
			S_LCMP: begin
				if (rt.rdata == s_r.orig) begin
					s_nxt.tgt = TRK_RSV;
					s_nxt.hd = {1'b0, s_r.si[4]} | HEAD_SPARE;
					s_nxt.sec = s_r.si[3:0];
					s_nxt = start_seek(s_nxt, S_XFER);
				end else begin
					s_nxt.si = s_r.si + 6'h01;
					s_nxt.st = S_LOOK;
				end
			end
			// One pulse per track toward dst
			S_STEP: begin
				if (s_r.cur == s_r.dst) begin
					if (s_r.fail) begin
						s_nxt.st = S_DEAD;
					end else if (s_r.ext) begin
						s_nxt.ext = 1'b0;
						s_nxt.dst = s_r.tgt;
					end else begin
						s_nxt.vi = '0;
						s_nxt.wt = 1'b0;
						s_nxt.st = S_VER;
					end
				end else begin
					s_nxt.stp = 1'b1;
					s_nxt.dir = s_r.dst > s_r.cur;
					s_nxt.cur = (s_r.dst > s_r.cur) ? s_r.cur + 8'h01 : s_r.cur - 8'h01;
					s_nxt.tmr = STEP_CYCLES;
					s_nxt.st = S_SWAIT;
				end
			end
			// Head settles before the next pulse or a read
			S_SWAIT: begin
				s_nxt.tmr = s_r.tmr - 32'h0000_0001;
				if (s_r.tmr <= 32'h0000_0001) begin
					s_nxt.tmr = '0;
					s_nxt.st = S_STEP;
				end
			end
			// Alternate sectors 0, 2, 4 on the landed track
			S_VER: begin
				if (!s_r.wt) begin
					s_nxt.go = 1'b1;
					s_nxt.wt = 1'b1;
				end else if (med_done) begin
					s_nxt.wt = 1'b0;
					if (hdr_good) begin
						s_nxt.vi = s_r.vi + 2'h1;
						if (s_r.vi == VER_LAST) begin
							s_nxt.st = s_r.ret;
						end
					end else begin
						s_nxt.vi = '0;
						s_nxt.errs = s_r.errs + 7'h01;
						if (s_r.errs == ERR_LIMIT) begin
							s_nxt.errs = '0;
							if (s_r.rph == RECAL_STEPS) begin
								if (!s_r.up) begin
									s_nxt.fail = 1'b1;
									s_nxt.dst = TRK_PARK;
									s_nxt.st = S_STEP;
								end else begin
									s_nxt.rv = (s_r.ret == S_XFER);
									s_nxt.rerr = 1'b1;
									s_nxt.st = S_IDLE;
								end
							end else begin
								s_nxt.dst = s_r.rph[0] ? TRK_INNER : TRK_OUTER;
								s_nxt.ext = 1'b1;
								s_nxt.rph = s_r.rph + 3'h1;
								s_nxt.st = S_STEP;
							end
						end
					end
				end
			end
			// Any table copy with good CRC will do
			S_LOAD: begin
				if (!s_r.wt) begin
					s_nxt.go = 1'b1;
					s_nxt.wt = 1'b1;
					s_nxt.hd = HEAD_TABLE + {1'b0, s_r.si[4]};
					s_nxt.sec = s_r.si[3:0];
				end else if (med_done) begin
					s_nxt.wt = 1'b0;
					if (med_crc_ok || (s_r.si == TBL_LAST)) begin
						s_nxt.tcnt = med_crc_ok ? s_r.tcnt : '0;
						s_nxt.up = 1'b1;
						s_nxt.st = S_IDLE;
					end else begin
						s_nxt.tcnt = '0;
						s_nxt.si = s_r.si + 6'h01;
					end
				end else if (med_ent_valid && (s_r.tcnt < SPARE_MAX)) begin
					rt.we = 1'b1;
					s_nxt.tcnt = s_r.tcnt + 6'h01;
				end
			end
			// Host transfer at the mapped location
			S_XFER: begin
				if (!s_r.wt) begin
					s_nxt.go = 1'b1;
					s_nxt.wt = 1'b1;
				end else if (med_done) begin
					s_nxt.wt = 1'b0;
					s_nxt.rv = 1'b1;
					s_nxt.rerr = !s_r.wr && !med_crc_ok;
					s_nxt.st = S_IDLE;
				end
			end
			// Salvaged data into its spare slot
			S_SCOPY: begin
				if (!s_r.wt) begin
					s_nxt.go = 1'b1;
					s_nxt.wt = 1'b1;
				end else if (med_done) begin
					rt.we = 1'b1;
					rt.waddr = s_r.si[4:0];
					rt.wdata = s_r.orig;
					s_nxt.tcnt = s_r.tcnt + 6'h01;
					s_nxt.si = '0;
					s_nxt.hd = HEAD_TABLE;
					s_nxt.wr = 1'b1;
					s_nxt = start_seek(s_nxt, S_TBLW);
				end
			end
			// Every table copy rewritten, both surfaces
			S_TBLW: begin
				if (!s_r.wt) begin
					s_nxt.go = 1'b1;
					s_nxt.wt = 1'b1;
					s_nxt.hd = HEAD_TABLE + {1'b0, s_r.si[4]};
					s_nxt.sec = s_r.si[3:0];
				end else if (med_done) begin
					s_nxt.wt = 1'b0;
					s_nxt.si = s_r.si + 6'h01;
					if (s_r.si == TBL_LAST) begin
						s_nxt.sdone = 1'b1;
						s_nxt.st = S_IDLE;
					end
				end
			end
			// Parked after a failed power-up; needs reset
			S_DEAD: begin
				s_nxt.st = S_DEAD;
			end
			default: begin
				s_nxt.st = S_DEAD;
			end
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	// Idle only follows completed power-up
	assign req_ready = (s_r.st == S_IDLE) && s_r.up && !spare_req;
	assign resp_valid = s_r.rv;
	assign resp_error = s_r.rerr;
	assign resp_addr = {s_r.hd, s_r.tgt, s_r.sec};
	assign spare_done = s_r.sdone;
	assign spare_full = s_r.tcnt == SPARE_MAX;
	assign step_pulse = s_r.stp;
	assign step_dir = s_r.dir;
	assign ready_lamp = (s_r.st == S_LAMP) || s_r.up;
	assign parked_fail = s_r.st == S_DEAD;
	assign med_go = s_r.go;
	assign med_write = s_r.wr && ((s_r.st == S_XFER) || (s_r.st == S_SCOPY) || (s_r.st == S_TBLW));
	assign med_head = s_r.hd;
	assign med_track = s_r.cur;
	// Verify reads fixed alternate positions
	assign med_sector = (s_r.st == S_VER) ? {1'b0, s_r.vi, 1'b0} : s_r.sec;
endmodule // seek_spare_mgr

// ---- test/seek_checker.sv ----
// Purpose: port timing checks for the seek and spare manager
// Assumes: shortened power-up counts handed on by the bind
// Notes: lamp windows keep one cycle of slack at each edge
`timescale 1ns/1ps
module seek_checker
	import seek_pkg::*;
#(
	parameter logic [31:0] LAMP_CYCLES = LAMP_CYC,
	parameter logic [31:0] SPIN_CYCLES = SPIN_CYC,
	parameter logic [31:0] STEP_CYCLES = STEP_CYC
) (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic req_valid,
	input wire logic req_ready,
	input wire logic req_write,
	input wire logic req_raw,
	input wire logic [7:0] req_track,
	input wire logic format_mode,
	input wire logic resp_valid,
	input wire logic resp_error,
	input wire logic spare_done,
	input wire logic step_pulse,
	input wire logic ready_lamp,
	input wire logic parked_fail,
	input wire logic med_go,
	input wire logic [1:0] med_head,
	input wire logic [7:0] med_track,
	input wire logic med_done
);
	// ----------------------------------------
	// Helper logic
	// ----------------------------------------
	logic [31:0] up_r;
	logic refuse;
	// Cycles since reset, saturating so long runs never wrap
	always_ff @(posedge core_clk) begin
		if (reset) begin
			up_r <= '0;
		end else if (up_r != 32'hffff_ffff) begin
			up_r <= up_r + 32'h0000_0001;
		end
	end
	assign refuse = req_valid && req_ready && req_write && req_raw && req_track == TRK_RSV && !format_mode;

	// ----------------------------------------
	// Properties
	// ----------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);
	sequence addr_held;
		$stable(med_track) && $stable(med_head) && !med_go;
	endsequence
	sequence quiet_pair;
		!med_go ##1 !med_go;
	endsequence
	resp_pulse_a: assert property (resp_valid |=> !resp_valid)
		else $error("response longer than one cycle");
	refuse_write_a: assert property (refuse |-> ##[1:2] (resp_valid && resp_error))
		else $error("reserved write not refused");
	refuse_quiet_a: assert property (refuse |=> quiet_pair)
		else $error("refused write reached media");
	step_quiet_a: assert property (step_pulse |=> quiet_pair)
		else $error("media op during step");
	lamp_on_a: assert property ((up_r < LAMP_CYCLES - 32'h0000_0001) |-> ready_lamp)
		else $error("lamp dark in supply phase");
	lamp_off_a: assert property ((up_r > LAMP_CYCLES && up_r < LAMP_CYCLES + SPIN_CYCLES - 32'h0000_0001)
		|-> !ready_lamp)
		else $error("lamp lit during spin-up");
	host_gate_a: assert property ((up_r < LAMP_CYCLES + SPIN_CYCLES) |-> !req_ready)
		else $error("host taken before power-up");
	addr_held_a: assert property (med_go |=> addr_held [*2])
		else $error("media address moved in op");
	park_dead_a: assert property (parked_fail |-> !req_ready && !med_go && !step_pulse)
		else $error("activity after park");
	spare_done_a: assert property (spare_done |-> $past(med_done) ##1 !spare_done)
		else $error("spare done not after media op");
	take_busy_a: assert property ((req_valid && req_ready && !req_write) |=> !req_ready)
		else $error("second request taken while busy");
endmodule // seek_checker

bind seek_spare_mgr seek_checker #(.LAMP_CYCLES(LAMP_CYCLES), .SPIN_CYCLES(SPIN_CYCLES),
	.STEP_CYCLES(STEP_CYCLES)) u_chk (.core_clk(core_clk), .reset(reset), .req_valid(req_valid),
	.req_ready(req_ready), .req_write(req_write), .req_raw(req_raw), .req_track(req_track),
	.format_mode(format_mode), .resp_valid(resp_valid), .resp_error(resp_error), .spare_done(spare_done),
	.step_pulse(step_pulse), .ready_lamp(ready_lamp), .parked_fail(parked_fail), .med_go(med_go),
	.med_head(med_head), .med_track(med_track), .med_done(med_done));

// ---- test/media_model.sv ----
// Purpose: drive and media stand-in behind the manager
// Assumes: heads start parked on track 0
// Notes: header reflects the real head position, not the request
`timescale 1ns/1ps
module media_model
	import seek_pkg::*;
(
	input wire logic core_clk,
	input wire logic step_pulse,
	input wire logic step_dir,
	input wire logic med_go,
	input wire logic [1:0] med_head,
	input wire logic bad_mode,
	input wire logic slow,
	output logic med_done,
	output logic med_hdr_ok,
	output logic [1:0] med_hdr_head,
	output logic [1:0] med_hdr_head_n,
	output logic [7:0] med_hdr_track,
	output logic [7:0] med_hdr_track_n,
	output logic med_crc_ok,
	output logic med_ent_valid,
	output paddr_t med_ent
);
	logic [7:0] pos_r = 8'h00;
	logic [1:0] head_r = 2'h0;
	logic [3:0] wait_r = 4'h0;
	logic busy_r = 1'b0;
	// Arm follows steps; reset does not move it
	always_ff @(posedge core_clk) begin
		if (step_pulse) begin
			pos_r <= step_dir ? pos_r + 8'h01 : pos_r - 8'h01;
		end
		med_done <= 1'b0;
		if (med_go) begin
			busy_r <= 1'b1;
			head_r <= med_head;
			wait_r <= slow ? 4'h6 : 4'h2;
		end else if (busy_r && wait_r == 4'h0) begin
			busy_r <= 1'b0;
			med_done <= 1'b1;
		end else if (busy_r) begin
			wait_r <= wait_r - 4'h1;
		end
	end
	// Status only meaningful with done; inverted otherwise
	assign med_hdr_ok = med_done;
	assign med_hdr_head = med_done ? head_r : ~head_r;
	assign med_hdr_head_n = ~med_hdr_head;
	assign med_hdr_track = med_done ? pos_r : ~pos_r;
	assign med_hdr_track_n = ~med_hdr_track;
	assign med_crc_ok = med_done && !bad_mode;
	assign med_ent_valid = 1'b0;
	assign med_ent = '0;
endmodule // media_model

// ---- test/disk_seek_and_spare_manager_tb.sv ----
// Purpose: self-checking bench for the seek and spare manager
// Assumes: shortened lamp, spin and step counts
// Notes: expected addresses come from the mapping function below, or are spare slots for relocated reads
`timescale 1ns/1ps
module disk_seek_and_spare_manager_tb;
	import seek_pkg::*;
	logic core_clk, reset, req_valid, req_write, req_raw, format_mode, host_type, spare_req, bad_mode, slow;
	logic req_ready, resp_valid, resp_error, spare_done, spare_full, step_pulse, step_dir, ready_lamp;
	logic parked_fail, med_go, med_write, med_done, med_hdr_ok, med_crc_ok, med_ent_valid, saw_tbl;
	logic [13:0] req_lba, lba;
	logic [7:0] req_track, med_track, med_hdr_track, med_hdr_track_n;
	logic [1:0] med_head, med_hdr_head, med_hdr_head_n;
	logic [3:0] med_sector;
	paddr_t spare_addr, resp_addr, med_ent;
	integer fails, samples_checked, seed, tbl_wr, spr_wr, i;

	seek_spare_mgr #(.LAMP_CYCLES(32'h0000_0014), .SPIN_CYCLES(32'h0000_0028), .STEP_CYCLES(32'h0000_0002)) u_dut (
		.core_clk(core_clk), .reset(reset), .req_valid(req_valid), .req_ready(req_ready),
		.req_write(req_write), .req_raw(req_raw), .req_lba(req_lba), .req_track(req_track),
		.format_mode(format_mode), .host_type(host_type), .resp_valid(resp_valid), .resp_error(resp_error),
		.resp_addr(resp_addr), .spare_req(spare_req), .spare_addr(spare_addr), .spare_done(spare_done),
		.spare_full(spare_full), .step_pulse(step_pulse), .step_dir(step_dir), .ready_lamp(ready_lamp),
		.parked_fail(parked_fail), .med_go(med_go), .med_write(med_write), .med_head(med_head),
		.med_track(med_track), .med_sector(med_sector), .med_done(med_done), .med_hdr_ok(med_hdr_ok),
		.med_hdr_head(med_hdr_head), .med_hdr_head_n(med_hdr_head_n), .med_hdr_track(med_hdr_track),
		.med_hdr_track_n(med_hdr_track_n), .med_crc_ok(med_crc_ok), .med_ent_valid(med_ent_valid),
		.med_ent(med_ent));
	media_model u_media (.core_clk(core_clk), .step_pulse(step_pulse), .step_dir(step_dir), .med_go(med_go),
		.med_head(med_head), .bad_mode(bad_mode), .slow(slow), .med_done(med_done), .med_hdr_ok(med_hdr_ok),
		.med_hdr_head(med_hdr_head), .med_hdr_head_n(med_hdr_head_n), .med_hdr_track(med_hdr_track),
		.med_hdr_track_n(med_hdr_track_n), .med_crc_ok(med_crc_ok), .med_ent_valid(med_ent_valid),
		.med_ent(med_ent));

	// ----------------------------------------
	// Clock, media monitor, helpers
	// ----------------------------------------
	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end
	// Tally media writes by area
	always @(posedge core_clk) begin
		if (med_go && med_write && med_head[1]) tbl_wr = tbl_wr + 1;
		if (med_go && med_write && !med_head[1] && med_track == TRK_RSV) spr_wr = spr_wr + 1;
		if (med_go && !med_write && med_head == HEAD_TABLE && med_track == TRK_RSV) saw_tbl = 1'b1;
	end
	// Tracks at or past the reserved one move up by one
	function automatic paddr_t map_lba(input logic [13:0] a, input logic ht);
		logic [7:0] trk;
		logic [7:0] pos;
		trk = (a[13:6] >= TRK_RSV) ? a[13:6] + 8'h01 : a[13:6];
		pos = a[3:0] * (ht ? IL_SECOND : IL_FIRST);
		return {a[5:4], trk, pos[3:0]};
	endfunction
	task automatic check(input logic [13:0] seen, input logic [13:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fails++;
			$display("[FAIL] %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task automatic host(input logic wr, input logic raw, input logic [13:0] a, input logic [7:0] trk);
		integer n;
		// Let an edge pass so a back-to-back call never re-raises valid in the step it was dropped
		@(posedge core_clk);
		#1;
		req_write = wr;
		req_raw = raw;
		req_lba = a;
		req_track = trk;
		req_valid = 1'b1;
		for (n = 0; n < 20000 && !req_ready; n++) begin @(posedge core_clk); #1; end
		@(posedge core_clk);
		#1 req_valid = 1'b0;
		for (n = 0; n < 20000 && !resp_valid; n++) begin @(posedge core_clk); #1; end
		check(resp_valid, 14'h0001);
	endtask
	// Level request dropped once the first media op shows it was taken
	task automatic spare(input paddr_t a);
		integer n;
		spare_addr = a;
		spare_req = 1'b1;
		for (n = 0; n < 20000 && !med_go; n++) begin @(posedge core_clk); #1; end
		spare_req = 1'b0;
		for (n = 0; n < 20000 && !spare_done; n++) begin @(posedge core_clk); #1; end
		check(spare_done, 14'h0001);
	endtask
	task automatic power_up();
		integer n;
		reset = 1'b1;
		saw_tbl = 1'b0;
		repeat (8) @(posedge core_clk);
		#1 reset = 1'b0;
		for (n = 0; n < 5000 && !req_ready && !parked_fail; n++) begin
			@(posedge core_clk);
			#1;
			if (n == 10) check(ready_lamp, 14'h0001);
			if (n == 40) check(ready_lamp, 14'h0000);
		end
		check(n >= 60, 14'h0001);
		check(saw_tbl, 14'h0001);
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		seed = 32'hbb9a;
		{fails, samples_checked, tbl_wr, spr_wr} = '0;
		{req_valid, req_write, req_raw, format_mode, host_type, spare_req, bad_mode, slow} = '0;
		req_lba = '0;
		req_track = '0;
		spare_addr = '0;
		power_up();
		// Random reads, with the tracks around the reserved one and the top one (0x97) forced
		for (i = 0; i < 24; i++) begin
			lba = $random(seed);
			lba[13:6] = (i == 0) ? 8'h4c : (i == 1) ? 8'h4d : (i == 2) ? 8'h97 : 8'($unsigned($random(seed)) % 152);
			host_type = $random(seed);
			slow = $random(seed);
			host(1'b0, 1'b0, lba, 8'h00);
			check(resp_addr, map_lba(lba, host_type));
			check(resp_error, 14'h0000);
		end
		// Reserved track write: refused, then accepted while formatting
		host(1'b1, 1'b1, 14'h0000, TRK_RSV);
		check(resp_error, 14'h0001);
		format_mode = 1'b1;
		host(1'b1, 1'b1, 14'h0000, TRK_RSV);
		check(resp_error, 14'h0000);
		format_mode = 1'b0;
		// Verify errors that clear well before the limit
		bad_mode = 1'b1;
		fork
			host(1'b0, 1'b0, 14'h0a45, 8'h00);
			begin repeat (10) @(posedge med_done); #1 bad_mode = 1'b0; end
		join
		check(resp_error, 14'h0000);
		// First relocation, then a read that must follow it
		host_type = 1'b0;
		{tbl_wr, spr_wr} = '0;
		spare(map_lba(14'h00d2, 1'b0));
		check(14'(tbl_wr), 14'h0020);
		check(14'(spr_wr), 14'h0001);
		host(1'b0, 1'b0, 14'h00d2, 8'h00);
		check(resp_addr, {HEAD_SPARE, TRK_RSV, 4'h0});
		check(spare_full, 14'h0000);
		for (i = 1; i < 32; i++) spare({2'h1, 8'(i), 4'h3});
		check(spare_full, 14'h0001);
		host(1'b0, 1'b0, {8'd31, 2'h1, 4'h7}, 8'h00);
		check(resp_addr, {2'h1, TRK_RSV, 4'hf});
		// Seek that never verifies: recalibrate, then error
		bad_mode = 1'b1;
		host(1'b0, 1'b0, {8'd40, 6'h00}, 8'h00);
		check(resp_error, 14'h0001);
		// Power-up that never verifies ends parked
		reset = 1'b1;
		repeat (8) @(posedge core_clk);
		#1 reset = 1'b0;
		for (i = 0; i < 60000 && !parked_fail; i++) begin @(posedge core_clk); #1; end
		check(parked_fail, 14'h0001);
		check(req_ready, 14'h0000);
		summarize();
	end
	// Hang guard, well past the expected run length
	initial begin
		#450000;
		fails++;
		summarize();
	end
endmodule // disk_seek_and_spare_manager_tb
